// ### rtl/dflm_monitor.sv
`timescale 1ns/1ps
`include "dflm_params.svh"
module dflm_monitor #(
	parameter int NFAULT    = 16,
	parameter int SPD_CYC   = `DFLM_SPD_ERR_S * `DFLM_CLK_HZ,
	parameter int FLASH_CYC = `DFLM_FLASH_CYC
) (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// raw fault conditions
	input  wire logic        overvolt_in,
	input  wire logic        undervolt_in,
	input  wire logic        overcur_in,
	input  wire logic        heatsink_in,
	input  wire logic        ambient_in,
	input  wire logic        ext_fault_supply_in,
	input  wire logic        input1_loss_in,
	input  wire logic        input2_loss_in,
	input  wire logic        motor_still_loaded_in,
	input  wire logic        invtime_limit_in,
	input  wire logic        brake_res_ovld_in,
	input  wire logic        brake_sw_ovld_in,
	input  wire logic        link_loss_flag_in,
	input  wire logic        speed_err_over_half_in,
	// sequencing and keypad
	input  wire logic        run_cmd_in,
	input  wire logic        contactor_feedback_in,
	input  wire logic        local_mode_in,
	input  wire logic        keypad_present_in,
	input  wire logic        stop_key_in,
	input  wire logic        escape_key_in,
	input  wire logic        enable_in,
	// outputs
	output logic             power_enable_out,
	output logic             fault_latched_flag_out,
	output logic             module_health_indicator_out,
	output logic             keypad_health_indicator_out,
	output logic             fault_message_out,
	output logic [3:0]       keypad_fault_source_out,
	// axi4-lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	if (NFAULT != 16 || SPD_CYC < 1 || FLASH_CYC < 1 || FLASH_CYC > 33554432) begin : g_bad_par
		$error("dflm_monitor: unsupported parameter");
	end

	// ==================================================
	// registers written by software
	logic [15:0] mask_q;
	logic [31:0] stall_lim_q;
	logic [31:0] cont_lim_q;
	logic        ext_mode_q;
	logic        msg_clr_q;

	// ==================================================
	// timed conditions
	logic [31:0] spd_cnt_q;
	logic [31:0] stall_cnt_q;
	logic [31:0] cont_cnt_q;
	logic        spd_hit;
	logic        stall_hit;
	logic        cont_hit;
	logic        enable_q;
	logic        kp_q;
	logic        toggle_clr;

	// speed error must stay high continuously
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) spd_cnt_q <= 32'h0000_0000;
		else if (!speed_err_over_half_in) spd_cnt_q <= 32'h0000_0000;
		else if (!spd_hit) spd_cnt_q <= spd_cnt_q + 32'h0000_0001;
	end
	assign spd_hit = (spd_cnt_q >= 32'(SPD_CYC));

	// stall timer, limit in clock cycles
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) stall_cnt_q <= 32'h0000_0000;
		else if (!motor_still_loaded_in) stall_cnt_q <= 32'h0000_0000;
		else if (!stall_hit) stall_cnt_q <= stall_cnt_q + 32'h0000_0001;
	end
	assign stall_hit = (stall_cnt_q > stall_lim_q);

	// contactor must close within window after run
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) cont_cnt_q <= 32'h0000_0000;
		else if (!run_cmd_in || contactor_feedback_in) cont_cnt_q <= 32'h0000_0000;
		else if (!cont_hit) cont_cnt_q <= cont_cnt_q + 32'h0000_0001;
	end
	assign cont_hit = (cont_cnt_q >= cont_lim_q);

	// edge history of enable and keypad presence
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enable_q <= 1'b1; // idle level, so no false rising edge after reset
			kp_q     <= 1'b0;
		end else begin
			enable_q <= enable_in;
			kp_q     <= keypad_present_in;
		end
	end
	assign toggle_clr = enable_in && !enable_q;

	// ==================================================
	// fault conditions and latches
	logic [15:0] cond;
	logic [15:0] effective;
	logic [15:0] latch_q;
	logic [3:0]  first_q;
	logic        first_valid_q;
	logic        reset_req;
	logic        cause_gone;

	always_comb begin
		cond = 16'h0000;
		cond[dflm_pkg::DFLM_F_OVERVOLT]  = overvolt_in;
		cond[dflm_pkg::DFLM_F_UNDERVOLT] = undervolt_in;
		cond[dflm_pkg::DFLM_F_OVERCUR]   = overcur_in;
		cond[dflm_pkg::DFLM_F_HEATSINK]  = heatsink_in;
		// mode 0 trips on missing supply, mode 1 on present supply
		cond[dflm_pkg::DFLM_F_EXTERNAL]  = ext_fault_supply_in == ext_mode_q;
		cond[dflm_pkg::DFLM_F_IN1_LOSS]  = input1_loss_in;
		cond[dflm_pkg::DFLM_F_IN2_LOSS]  = input2_loss_in;
		cond[dflm_pkg::DFLM_F_STALL]     = stall_hit;
		cond[dflm_pkg::DFLM_F_INVTIME]   = invtime_limit_in;
		cond[dflm_pkg::DFLM_F_BRK_RES]   = brake_res_ovld_in;
		cond[dflm_pkg::DFLM_F_BRK_SW]    = brake_sw_ovld_in;
		cond[dflm_pkg::DFLM_F_KEYPAD]    = kp_q && !keypad_present_in
			&& run_cmd_in && local_mode_in;
		cond[dflm_pkg::DFLM_F_LINK]      = link_loss_flag_in;
		cond[dflm_pkg::DFLM_F_CONTACTOR] = cont_hit;
		cond[dflm_pkg::DFLM_F_SPEED]     = spd_hit;
		cond[dflm_pkg::DFLM_F_AMBIENT]   = ambient_in;
	end
	// mask honoured only where the fault allows it
	assign effective  = cond & ~(mask_q & ~`DFLM_NOMASK);
	assign reset_req  = stop_key_in || toggle_clr;
	assign cause_gone = (effective == 16'h0000);

	// one latch per fault; a new event wins over a reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) latch_q <= 16'h0000;
		else if (reset_req && cause_gone) latch_q <= 16'h0000;
		else latch_q <= latch_q | effective;
	end

	// first fault code, lowest position wins a tie
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			first_q       <= 4'h0;
			first_valid_q <= 1'b0;
		end else if (reset_req && cause_gone) begin
			first_valid_q <= 1'b0;
		end else if (!first_valid_q && effective != 16'h0000) begin
			first_valid_q <= 1'b1;
			for (int i = 15; i >= 0; i--) begin
				if (effective[i]) first_q <= 4'(i);
			end
		end
	end

	// ==================================================
	// trip state
	dflm_pkg::dflm_state_t state_q;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) state_q <= dflm_pkg::DFLM_ST_RUN_OK;
		else begin
			case (state_q)
				dflm_pkg::DFLM_ST_RUN_OK: begin
					if (effective != 16'h0000) state_q <= dflm_pkg::DFLM_ST_FAULT_LATCHED_FLAG;
				end
				dflm_pkg::DFLM_ST_FAULT_LATCHED_FLAG: begin
					if (reset_req && cause_gone) state_q <= dflm_pkg::DFLM_ST_CLEARING;
				end
				default: begin
					// one cycle before run may be granted again
					if (effective != 16'h0000) state_q <= dflm_pkg::DFLM_ST_FAULT_LATCHED_FLAG;
					else state_q <= dflm_pkg::DFLM_ST_RUN_OK;
				end
			endcase
		end
	end

	// ==================================================
	// outputs, power cut combines the raw fault to save a cycle
	logic        fault_latched_flag;
	logic [24:0] flash_cnt_q;
	logic        flash_q;
	logic        msg_q;
	assign fault_latched_flag = (latch_q != 16'h0000) || (effective != 16'h0000);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			power_enable_out            <= 1'b0;
			fault_latched_flag_out      <= 1'b0;
			module_health_indicator_out <= 1'b0;
		end else begin
			power_enable_out            <= run_cmd_in && enable_in && !fault_latched_flag
				&& state_q == dflm_pkg::DFLM_ST_RUN_OK;
			fault_latched_flag_out      <= fault_latched_flag;
			module_health_indicator_out <= fault_latched_flag;
		end
	end

	// keypad blink while fault_latched_flag
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flash_cnt_q <= 25'h000_0000;
			flash_q     <= 1'b0;
		end else if (!fault_latched_flag) begin
			flash_cnt_q <= 25'h000_0000;
			flash_q     <= 1'b0;
		end else if (flash_cnt_q >= 25'(FLASH_CYC - 1)) begin
			flash_cnt_q <= 25'h000_0000;
			flash_q     <= !flash_q;
		end else flash_cnt_q <= flash_cnt_q + 25'h000_0001;
	end

	// message shown on trip; escape or software hides it, stop acknowledges
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) msg_q <= 1'b0;
		else if (effective != 16'h0000 && !first_valid_q) msg_q <= 1'b1;
		else if (escape_key_in || msg_clr_q || (reset_req && cause_gone)) msg_q <= 1'b0;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			keypad_health_indicator_out <= 1'b0;
			keypad_fault_source_out     <= 4'h0;
			fault_message_out           <= 1'b0;
		end else begin
			keypad_health_indicator_out <= keypad_present_in && fault_latched_flag && flash_q;
			keypad_fault_source_out     <= (keypad_present_in && first_valid_q)
				? first_q : 4'h0;
			fault_message_out           <= keypad_present_in && msg_q;
		end
	end

	// ==================================================
	// axi4-lite write channel
	logic        aw_q;
	logic        w_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_go;
	logic [11:0] wa;
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	// decode on the word, byte offset bits ignored
	assign wa    = {awaddr_q[11:2], 2'b00};

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_go) aw_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_go) w_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				if (wa == `DFLM_OFS_MASK || wa == `DFLM_OFS_CTRL
					|| wa == `DFLM_OFS_STALL_TIME || wa == `DFLM_OFS_CONT_TIME)
					s_axi_bresp <= 2'b00;
				else s_axi_bresp <= 2'b10;
			end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
		end
	end

	// register stores, byte lanes honoured
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_q      <= `DFLM_MASK_RST;
			stall_lim_q <= `DFLM_STALL_RST;
			cont_lim_q  <= `DFLM_CONT_RST;
			ext_mode_q  <= 1'b0;
			msg_clr_q   <= 1'b0;
		end else begin
			msg_clr_q <= 1'b0;
			if (wr_go) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_q[b]) begin
						if (wa == `DFLM_OFS_MASK) begin
							if (b < 2) mask_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						end else if (wa == `DFLM_OFS_STALL_TIME) begin
							stall_lim_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						end else if (wa == `DFLM_OFS_CONT_TIME) begin
							cont_lim_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
						end else if (wa == `DFLM_OFS_CTRL && b == 0) begin
							ext_mode_q <= wdata_q[`DFLM_CTRL_EXTMODE];
							msg_clr_q  <= wdata_q[`DFLM_CTRL_MSGCLR];
						end
					end
				end
			end
		end
	end

	// ==================================================
	// axi4-lite read channel
	logic [11:0] ra;
	assign ra = {s_axi_araddr[11:2], 2'b00};
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				if (ra == `DFLM_OFS_STATUS)
					s_axi_rdata <= {24'h00_0000, first_valid_q, fault_latched_flag, state_q, first_q};
				else if (ra == `DFLM_OFS_ACTIVE)
					s_axi_rdata <= {16'h0000, latch_q};
				else if (ra == `DFLM_OFS_MASK)
					s_axi_rdata <= {16'h0000, mask_q};
				else if (ra == `DFLM_OFS_CTRL)
					s_axi_rdata <= {31'h0000_0000, ext_mode_q};
				else if (ra == `DFLM_OFS_STALL_TIME)
					s_axi_rdata <= stall_lim_q;
				else if (ra == `DFLM_OFS_CONT_TIME)
					s_axi_rdata <= cont_lim_q;
				else if (ra == `DFLM_OFS_CAUSE)
					s_axi_rdata <= {16'h0000, effective};
				else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dflm_monitor

// ### rtl/dflm_params.svh
// Function
// - fault drops power stage enable at once
// - faults stay latched until explicit reset
// - fault_latched_flag flag high while any fault latched
// - first fault code recorded in status
// - module health indicators red while fault_latched_flag
// - keypad indicator flashes, shows fault source
// - stop acknowledges; escape only clears message
// - reset ignored while cause still present
// - stop clears when cause gone, then run
// - enable toggle or power cycle clears faults
// - independent latch per fault
// - speed error over half scale ten seconds
// - inverse time limit active trips overload
// - contactor feedback false after run command
// - external fault input low, mode selectable
// - input one or two loss trips
// - link loss flag trips
// - keypad unplugged while running locally trips
// - separate over and under voltage faults
// - stall longer than configured duration trips
// - distinct resistor and switch overload faults
// - mask ignored for non maskable faults
`ifndef DFLM_PARAMS_SVH
`define DFLM_PARAMS_SVH
// register byte offsets
`define DFLM_OFS_STATUS     12'h000
`define DFLM_OFS_ACTIVE     12'h004
`define DFLM_OFS_MASK       12'h008
`define DFLM_OFS_CTRL       12'h00C
`define DFLM_OFS_STALL_TIME 12'h010
`define DFLM_OFS_CONT_TIME  12'h014
`define DFLM_OFS_CAUSE      12'h018
// reset values and non maskable fault set
`define DFLM_MASK_RST       16'h0000
`define DFLM_NOMASK         16'h0FFF
`define DFLM_STALL_RST      32'h0000_0064
`define DFLM_CONT_RST       32'h0000_0064
// control fields
`define DFLM_CTRL_EXTMODE   0
`define DFLM_CTRL_MSGCLR    1
// timing
`define DFLM_SPD_ERR_S      10
`define DFLM_CLK_HZ         100000000
`define DFLM_FLASH_CYC      25000000
`endif

// ### rtl/dflm_pkg.sv
package dflm_pkg;
	// fault bit positions, code = position
	typedef enum logic [3:0] {
		DFLM_F_OVERVOLT = 4'h0, DFLM_F_UNDERVOLT = 4'h1, DFLM_F_OVERCUR = 4'h2,
		DFLM_F_HEATSINK = 4'h3, DFLM_F_EXTERNAL = 4'h4, DFLM_F_IN1_LOSS = 4'h5,
		DFLM_F_IN2_LOSS = 4'h6, DFLM_F_STALL = 4'h7, DFLM_F_INVTIME = 4'h8,
		DFLM_F_BRK_RES = 4'h9, DFLM_F_BRK_SW = 4'hA, DFLM_F_KEYPAD = 4'hB,
		DFLM_F_LINK = 4'hC, DFLM_F_CONTACTOR = 4'hD, DFLM_F_SPEED = 4'hE,
		DFLM_F_AMBIENT = 4'hF
	} dflm_fault_t;
	typedef enum logic [1:0] {
		DFLM_ST_RUN_OK = 2'b00, DFLM_ST_FAULT_LATCHED_FLAG = 2'b01, DFLM_ST_CLEARING = 2'b11
	} dflm_state_t;
endpackage : dflm_pkg

// ### tb/dflm_monitor_chk.sv
`timescale 1ns/1ps
// ==========
// fault monitor port checker
module dflm_monitor_chk (
	// clock and reset
	input wire logic       sys_clk_in,
	input wire logic       rst_n_in,
	// fault causes
	input wire logic       overvolt_in,
	input wire logic       overcur_in,
	input wire logic       heatsink_in,
	input wire logic       brake_sw_ovld_in,
	input wire logic       brake_res_ovld_in,
	input wire logic       input1_loss_in,
	input wire logic       input2_loss_in,
	// operator side
	input wire logic       stop_key_in,
	input wire logic       enable_in,
	input wire logic       run_cmd_in,
	input wire logic       keypad_present_in,
	// outputs
	input wire logic       power_enable_out,
	input wire logic       fault_latched_flag_out,
	input wire logic       module_health_indicator_out,
	input wire logic       keypad_health_indicator_out,
	input wire logic [3:0] keypad_fault_source_out,
	input wire logic       s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	// ==========
	// power stage and latch
	a_trip_cuts_power: assert property ((overvolt_in || overcur_in || heatsink_in ||
		brake_sw_ovld_in) |=> !power_enable_out) else $error("power stayed on after fault");
	a_trip_blocks_power: assert property (fault_latched_flag_out |-> !power_enable_out)
		else $error("power on while fault_latched_flag");
	// no reset request in two cycles means nothing may clear the latch
	a_latch_holds: assert property ((!stop_key_in && $stable(enable_in))[*2]
		##0 fault_latched_flag_out |=> fault_latched_flag_out) else $error("latch lost");
	a_flag_lights_led: assert property (fault_latched_flag_out == module_health_indicator_out)
		else $error("health indicator differs from flag");
	a_busy_stop_ignored: assert property (heatsink_in && stop_key_in |=> fault_latched_flag_out)
		else $error("stop cleared a present fault");
	a_loss_trips: assert property ((input1_loss_in || input2_loss_in) |=> fault_latched_flag_out)
		else $error("input loss did not trip");
	a_brake_trips: assert property ($rose(brake_res_ovld_in) |-> ##1 fault_latched_flag_out[*2])
		else $error("brake overload did not trip");
	a_power_needs_run: assert property (!(run_cmd_in && enable_in) |=> !power_enable_out)
		else $error("power on without run and enable");
	a_source_hidden: assert property (!$past(keypad_present_in) |-> keypad_fault_source_out == 4'h0)
		else $error("source shown without keypad");
	// ==========
	// main scenarios
	c_trip: cover property ($rose(fault_latched_flag_out));
	c_run: cover property ($rose(power_enable_out));
	c_blink: cover property ($rose(keypad_health_indicator_out));
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : dflm_monitor_chk

bind dflm_monitor dflm_monitor_chk i_dflm_monitor_chk (
	.sys_clk_in, .rst_n_in, .overvolt_in, .overcur_in, .heatsink_in, .brake_sw_ovld_in,
	.brake_res_ovld_in, .input1_loss_in, .input2_loss_in, .stop_key_in, .enable_in, .run_cmd_in,
	.keypad_present_in, .power_enable_out, .fault_latched_flag_out, .module_health_indicator_out,
	.keypad_health_indicator_out, .keypad_fault_source_out, .s_axi_bvalid, .s_axi_bresp);

// ### tb/dflm_panel.sv
`timescale 1ns/1ps
// ==========
// keypad and control terminal model
module dflm_panel (
	// clock
	input wire logic sys_clk_in,
	// operator levels
	output logic     stop_key_out,
	output logic     escape_key_out,
	output logic     enable_out,
	output logic     keypad_present_out,
	output logic     local_mode_out,
	output logic     run_cmd_out,
	output logic     contactor_feedback_out
);
	logic       stuck_q;
	logic [2:0] dly_q;
	// idle panel: enabled, keypad plugged, remote, stopped
	initial begin
		{stop_key_out, escape_key_out, local_mode_out, run_cmd_out, stuck_q} = 5'h00;
		{enable_out, keypad_present_out} = 2'h3;
	end
	// contactor closes a few cycles after run, unless told to stick open
	always @(posedge sys_clk_in) begin
		dly_q <= {dly_q[1:0], run_cmd_out && !stuck_q};
		contactor_feedback_out <= dly_q[2];
	end
	// key press held n cycles; stop acknowledges, escape only hides
	task automatic press(input int k, input int n);
		@(posedge sys_clk_in);
		if (k == 0) stop_key_out <= 1'b1;
		else escape_key_out <= 1'b1;
		repeat (n) @(posedge sys_clk_in);
		stop_key_out <= 1'b0;
		escape_key_out <= 1'b0;
	endtask : press
	// level changes: enable, keypad, local, run, stuck contactor
	task automatic set(input int k, input logic v);
		@(posedge sys_clk_in);
		case (k)
			0: enable_out <= v;
			1: keypad_present_out <= v;
			2: local_mode_out <= v;
			3: run_cmd_out <= v;
			default: stuck_q <= v;
		endcase
	endtask : set
endmodule : dflm_panel

// ### tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
	logic        sys_clk_in, rst_n_in, stop_key_in, escape_key_in, enable_in, keypad_present_in;
	logic        local_mode_in, run_cmd_in, contactor_feedback_in, power_enable_out;
	logic        fault_latched_flag_out, module_health_indicator_out, fault_message_out;
	logic        keypad_health_indicator_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, lv;
	logic [15:0] flt;
	logic [3:0]  keypad_fault_source_out, s_axi_wstrb, q;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rs, ev, mv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, br;
	logic [31:0] exq[$], mkq[$];
	int          n_mismatch, total_checks, nb;
	logic [3:0]  fl [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC, 4'hF};
	// ==========
	// clock, design, partner
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	// short speed and blink counts keep the run brief
	dflm_monitor #(.SPD_CYC(20), .FLASH_CYC(4)) i_dflm_monitor (.sys_clk_in, .rst_n_in,
		.overvolt_in(flt[0]), .undervolt_in(flt[1]), .overcur_in(flt[2]), .heatsink_in(flt[3]),
		.ext_fault_supply_in(~flt[4]), .input1_loss_in(flt[5]), .input2_loss_in(flt[6]),
		.motor_still_loaded_in(flt[7]), .invtime_limit_in(flt[8]), .brake_res_ovld_in(flt[9]),
		.brake_sw_ovld_in(flt[10]), .link_loss_flag_in(flt[12]), .speed_err_over_half_in(flt[14]),
		.ambient_in(flt[15]), .run_cmd_in, .contactor_feedback_in, .local_mode_in,
		.keypad_present_in, .stop_key_in, .escape_key_in, .enable_in, .power_enable_out,
		.fault_latched_flag_out, .module_health_indicator_out, .keypad_health_indicator_out,
		.fault_message_out, .keypad_fault_source_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	dflm_panel i_dflm_panel (.sys_clk_in, .stop_key_out(stop_key_in), .escape_key_out(escape_key_in),
		.enable_out(enable_in), .keypad_present_out(keypad_present_in),
		.local_mode_out(local_mode_in), .run_cmd_out(run_cmd_in),
		.contactor_feedback_out(contactor_feedback_in));
	// ==========
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic sig(input int k);
		return k ? power_enable_out : fault_latched_flag_out;
	endfunction : sig
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge sys_clk_in);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		// address and data are released each at its own handshake
		while (aw || w) begin
			@(posedge sys_clk_in);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk_in); while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge sys_clk_in);
		exq.push_back(e & m);
		mkq.push_back(m);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
		do @(posedge sys_clk_in); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk_in); while (!s_axi_rvalid);
		br = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic code_is(input logic [3:0] c);
		rd(12'h000, {24'h00_0000, 4'hC, c}, 32'h0000_00cf);
	endtask : code_is
	// bounded wait for the flag (k=0) or power enable (k=1) to reach v
	task automatic await(input int k, input logic v, input int n);
		repeat (n) begin
			@(posedge sys_clk_in);
			if (sig(k) === v) break;
		end
		`CHK(k ? "power" : "flag", v, sig(k))
	endtask : await
	task automatic pulse(input logic [3:0] p);
		@(posedge sys_clk_in) flt[p] <= 1'b1;
		@(posedge sys_clk_in) flt[p] <= 1'b0;
	endtask : pulse
	task automatic clr();
		i_dflm_panel.press(0, 2);
		await(0, 1'b0, 10);
	endtask : clr
	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// ==========
	// read results compared in order of issue
	always @(posedge sys_clk_in) begin
		if (s_axi_rvalid && s_axi_rready) begin
			ev = exq.pop_front();
			mv = mkq.pop_front();
			`CHK("rdata", ev, s_axi_rdata & mv)
		end
	end
	// watchdog sized well above the whole sequence
	initial begin
		repeat (30000) @(posedge sys_clk_in);
		n_mismatch++;
		close_out();
	end
	// ==========
	// scenarios
	initial begin
		{rst_n_in, flt, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 20'h0_0000;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 58'h0;
		s_axi_wstrb = 4'hF;
		rs = 32'h24f6_b461;
		repeat (8) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		rd(12'h010, 32'h0000_0064, 32'hffff_ffff);
		rd(12'h014, 32'h0000_0064, 32'hffff_ffff);
		rd(12'h008, 32'h0000_0000, 32'hffff_ffff);
		wr(12'hff0, 32'h0000_0001);
		`CHK("bresp", 2'b10, br)
		rd(12'hff0, 32'h0000_0000, 32'hffff_ffff);
		`CHK("rresp", 2'b10, br)
		i_dflm_panel.set(3, 1'b1);
		await(1, 1'b1, 12);
		done("registers");
		// every direct fault, a random later one must not steal the first code
		foreach (fl[i]) begin
			rs = lfsr(rs);
			q = fl[rs % 12];
			pulse(fl[i]);
			pulse(q);
			await(0, 1'b1, 4);
			`CHK("pwr", 1'b0, power_enable_out)
			`CHK("led", 1'b1, module_health_indicator_out)
			`CHK("src", fl[i], keypad_fault_source_out)
			code_is(fl[i]);
			rd(12'h004, (32'h0000_0001 << fl[i]) | (32'h0000_0001 << q), 32'h0000_ffff);
			clr();
			rd(12'h000, 32'h0000_0000, 32'h0000_00c0);
			await(1, 1'b1, 12);
		end
		done("each fault");
		@(posedge sys_clk_in) flt[3] <= 1'b1;
		await(0, 1'b1, 4);
		i_dflm_panel.press(0, 2);
		repeat (4) @(posedge sys_clk_in);
		`CHK("flag", 1'b1, fault_latched_flag_out)
		@(posedge sys_clk_in) flt[3] <= 1'b0;
		clr();
		done("cause present");
		pulse(4'h0);
		await(0, 1'b1, 4);
		@(posedge sys_clk_in); // message lags the flag by one cycle
		`CHK("msg", 1'b1, fault_message_out)
		nb = 0;
		lv = keypad_health_indicator_out;
		repeat (20) begin
			@(posedge sys_clk_in);
			nb += int'(keypad_health_indicator_out !== lv);
			lv = keypad_health_indicator_out;
		end
		`CHK("blink", 1'b1, nb > 1)
		i_dflm_panel.press(1, 1);
		repeat (3) @(posedge sys_clk_in);
		`CHK("msg", 1'b0, fault_message_out)
		`CHK("flag", 1'b1, fault_latched_flag_out)
		clr();
		done("keypad");
		pulse(4'h2);
		await(0, 1'b1, 4);
		i_dflm_panel.set(0, 1'b0);
		repeat (3) @(posedge sys_clk_in);
		i_dflm_panel.set(0, 1'b1);
		await(0, 1'b0, 10);
		done("enable toggle");
		@(posedge sys_clk_in) flt[14] <= 1'b1;
		repeat (15) @(posedge sys_clk_in);
		flt[14] <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		`CHK("flag", 1'b0, fault_latched_flag_out)
		flt[14] <= 1'b1;
		await(0, 1'b1, 30);
		flt[14] <= 1'b0;
		code_is(4'hE);
		clr();
		@(posedge sys_clk_in) flt[7] <= 1'b1;
		repeat (90) @(posedge sys_clk_in);
		`CHK("flag", 1'b0, fault_latched_flag_out)
		await(0, 1'b1, 30);
		flt[7] <= 1'b0;
		code_is(4'h7);
		clr();
		i_dflm_panel.set(4, 1'b1);
		await(0, 1'b1, 130);
		code_is(4'hD);
		i_dflm_panel.set(4, 1'b0);
		repeat (5) @(posedge sys_clk_in);
		clr();
		done("timed faults");
		i_dflm_panel.set(2, 1'b1);
		i_dflm_panel.set(1, 1'b0);
		await(0, 1'b1, 4);
		code_is(4'hB);
		i_dflm_panel.set(1, 1'b1);
		i_dflm_panel.set(2, 1'b0);
		clr();
		wr(12'h008, 32'h0000_ffff);
		pulse(4'hC);
		repeat (4) @(posedge sys_clk_in);
		`CHK("flag", 1'b0, fault_latched_flag_out)
		pulse(4'h0);
		await(0, 1'b1, 4);
		clr();
		wr(12'h008, 32'h0000_0000);
		wr(12'h00c, 32'h0000_0001);
		await(0, 1'b1, 4);
		code_is(4'h4);
		wr(12'h00c, 32'h0000_0002);
		repeat (2) @(posedge sys_clk_in);
		`CHK("msg", 1'b0, fault_message_out)
		clr();
		done("keypad loss and mask");
		pulse(4'h1);
		await(0, 1'b1, 4);
		@(posedge sys_clk_in) rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		`CHK("flag", 1'b0, fault_latched_flag_out)
		done("power cycle");
		close_out();
	end
endmodule : tb
